//--- cfd_pkg.sv
/*
  Package for the CPU status byte and first-map opcode decode block.
  Assumes a single core clock domain; no timing constants are needed.
*/
package cfd_pkg;
  localparam int unsigned FLAG_C_POS = 7;
  localparam int unsigned FLAG_Z_POS = 6;
  localparam int unsigned FLAG_S_POS = 5;
  localparam int unsigned FLAG_V_POS = 4;
  localparam int unsigned FLAG_D_POS = 3;
  localparam int unsigned FLAG_H_POS = 2;
  localparam int unsigned FLAG_U2_POS = 1;
  localparam int unsigned FLAG_U1_POS = 0;

  // Software register map on the plain register port
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_DECODE = 4'h1;
  localparam logic [3:0] ADDR_SAVED = 4'h2;
  localparam logic [3:0] ADDR_COND = 4'h3;

  localparam logic [5:0] ARITH_FLAGS_RESET = 6'h00;
  localparam logic [7:0] PREFIX_OPCODE = 8'h1F;
  localparam logic [7:0] OPC_TRAP = 8'hF2;
  localparam logic [7:0] OPC_INTERRUPT_RETURN_INSTR = 8'hBF;
  localparam logic [7:0] OPC_JR_CC = 8'h0B;
  localparam logic [7:0] OPC_JP_CC = 8'h0D;
  localparam logic [3:0] SAVE_DEPTH = 4'h8;

  typedef enum logic [3:0] {
    CFD_CC_F = 4'h0, CFD_CC_LT = 4'h1, CFD_CC_LE = 4'h2, CFD_CC_ULE = 4'h3,
    CFD_CC_OV = 4'h4, CFD_CC_MI = 4'h5, CFD_CC_Z = 4'h6, CFD_CC_C = 4'h7,
    CFD_CC_T = 4'h8, CFD_CC_GE = 4'h9, CFD_CC_GT = 4'hA, CFD_CC_UGT = 4'hB,
    CFD_CC_NOV = 4'hC, CFD_CC_PL = 4'hD, CFD_CC_NZ = 4'hE, CFD_CC_NC = 4'hF
  } cfd_cc_t;

  typedef enum logic [1:0] {
    CFD_MAP_FIRST = 2'b00,
    CFD_MAP_SECOND = 2'b01
  } cfd_map_t;
endpackage : cfd_pkg

//--- cfd_stack_mem.sv
/*
  Small stack memory holding saved status bytes.
  Assumes the caller never pushes past depth; read data registered.
*/
`timescale 1ns/1ns
module cfd_stack_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic core_clk, // core clock
  input wire logic wr_en, // write strobe
  input wire logic [AW-1:0] wr_addr, // write address
  input wire logic [WIDTH-1:0] wr_data, // write data
  input wire logic [AW-1:0] rd_addr, // read address
  output logic [WIDTH-1:0] rd_data // registered read data
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
    rd_data <= mem_reg[rd_addr];
  end
endmodule : cfd_stack_mem

//--- cfd_flags_decode.sv
/*
  Status byte, branch condition evaluation, save/restore on trap and
  interrupt return, index sign extension and first-map opcode decode.
  Assumes fetch and datapath run on core_clk and present one-cycle strobes.
  Assumes entry and return never arrive in the same cycle; if they do,
  the push wins the pointer unless the stack is full, and the return still restores the old top.
  Assumes software writes the user bits before it relies on them, since
  neither power-up nor reset gives them a value.
  The save stack holds eight bytes; a further entry replaces the newest.
*/
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module cfd_flags_decode import cfd_pkg::*; #(
  parameter int ADDR_W = 16,
  parameter int STACK_AW = 3
) (
  input wire logic core_clk, // core clock
  input wire logic rst, // async reset, high
  input wire logic alu_update, // ALU op finished
  input wire logic [5:0] alu_flags, // C Z S V D H from datapath
  input wire logic [5:0] alu_mask, // which flags this op affects
  input wire logic user_wr, // explicit user bit write
  input wire logic [1:0] user_val, // new user bits {two, one}
  input wire logic entry_evt, // interrupt, trap or illegal trap
  input wire logic interrupt_return_instr, // return executed
  input wire logic op_valid, // opcode byte strobe
  input wire logic [7:0] op_byte, // opcode byte
  input wire logic [3:0] cc_code, // jump condition code
  input wire logic [ADDR_W-1:0] base_addr, // base for indexing
  input wire logic [7:0] index_byte, // signed index
  input wire logic [3:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  output logic [7:0] reg_rdata, // read data, cycle after read
  output logic [7:0] status_out, // status byte
  output logic branch_taken, // condition result
  output logic [7:0] push_data, // byte to stack
  output logic push_valid, // push strobe
  output logic map_sel, // 1 = second map active
  output logic [3:0] op_upper, // decoded row
  output logic [3:0] op_lower, // decoded column
  output logic op_strobe, // decoded first-map opcode
  output logic [ADDR_W-1:0] eff_addr // indexed address
);
  logic [5:0] arith_reg;
  logic [5:0] arith_next;
  logic [1:0] user_reg;
  logic [1:0] user_next;
  localparam int SP_W = STACK_AW + 1;
  logic [SP_W-1:0] sp_reg;
  logic [SP_W-1:0] sp_next;
  logic stack_full;
  logic [STACK_AW-1:0] top_addr;
  logic [STACK_AW-1:0] push_addr;
  logic [5:0] alu_merge;
  logic [7:0] rdata_next;
  logic [7:0] push_next;
  logic [ADDR_W-1:0] eff_next;
  logic sgn_lt;
  logic sgn_le;
  logic uns_le;
  logic [7:0] status_next;
  logic map_second;
  logic restore_pend_reg;
  cfd_map_t map_reg;
  cfd_map_t map_next;
  logic [7:0] stack_rd;
  logic cc_hit;
  logic c_f;
  logic z_f;
  logic s_f;
  logic v_f;
  logic is_prefix;
  logic first_op;
  logic [7:0] status_now;
  logic [ADDR_W-1:0] idx_ext;
  logic [7:0] rd_mux;
  logic wr_status;
  logic do_pop;

  // C Z S V D H U2 U1, bit 7 down to 0
  assign status_now = {arith_reg, user_reg};
  assign c_f = arith_reg[FLAG_C_POS-2];
  assign z_f = arith_reg[FLAG_Z_POS-2];
  assign s_f = arith_reg[FLAG_S_POS-2];
  assign v_f = arith_reg[FLAG_V_POS-2];
  // Compares shared by a condition and its inverse
  assign sgn_lt = s_f ^ v_f;
  assign sgn_le = z_f | sgn_lt;
  assign uns_le = c_f | z_f;
  assign wr_status = reg_wr && (reg_addr == ADDR_STATUS);
  assign do_pop = interrupt_return_instr && (sp_reg != '0);

  // Only C Z S V are wired in; H, D and user bits cannot reach a branch
  always_comb begin
    case (cfd_cc_t'(cc_code))
      CFD_CC_F: cc_hit = 1'b0;
      CFD_CC_LT: cc_hit = sgn_lt;
      CFD_CC_LE: cc_hit = sgn_le;
      CFD_CC_ULE: cc_hit = uns_le;
      CFD_CC_OV: cc_hit = v_f;
      CFD_CC_MI: cc_hit = s_f;
      CFD_CC_Z: cc_hit = z_f;
      CFD_CC_C: cc_hit = c_f;
      CFD_CC_T: cc_hit = 1'b1;
      CFD_CC_GE: cc_hit = ~sgn_lt;
      CFD_CC_GT: cc_hit = ~sgn_le;
      CFD_CC_UGT: cc_hit = ~uns_le;
      CFD_CC_NOV: cc_hit = ~v_f;
      CFD_CC_PL: cc_hit = ~s_f;
      CFD_CC_NZ: cc_hit = ~z_f;
      CFD_CC_NC: cc_hit = ~c_f;
      default: cc_hit = 1'b0;
    endcase
  end

  // One cell per arithmetic flag: an op rewrites only the flags it masks
  generate
    for (genvar gi = 0; gi < 6; gi++) begin : g_flag_cell
      assign alu_merge[gi] = alu_mask[gi] ? alu_flags[gi] : arith_reg[gi];
    end
  endgenerate

  // Restore beats a same-cycle ALU update and a register write
  always_comb begin
    arith_next = arith_reg;
    user_next = user_reg;
    if (restore_pend_reg) begin
      {arith_next, user_next} = stack_rd;
    end else if (wr_status) begin
      {arith_next, user_next} = reg_wdata;
    end else begin
      if (alu_update) begin
        arith_next = alu_merge;
      end
      if (user_wr) begin
        user_next = user_val;
      end
    end
  end

  // Pointer counts entries, so a full stack is told apart from an empty one
  assign stack_full = (sp_reg == SP_W'(SAVE_DEPTH));
  assign top_addr = STACK_AW'(sp_reg - 1'b1);
  // Once full, a further entry overwrites the newest byte; older ones survive
  assign push_addr = stack_full ? top_addr : sp_reg[STACK_AW-1:0];

  always_comb begin
    sp_next = sp_reg;
    if (entry_evt && !stack_full) begin
      sp_next = sp_reg + 1'b1;
    end else if (do_pop) begin
      sp_next = sp_reg - 1'b1;
    end
  end

  // Prefix arms the second map for exactly the following byte
  assign is_prefix = (op_byte == PREFIX_OPCODE);
  assign first_op = op_valid && (map_reg == CFD_MAP_FIRST) && !is_prefix;
  always_comb begin
    map_next = map_reg;
    if (op_valid) begin
      if ((map_reg == CFD_MAP_FIRST) && is_prefix) begin
        map_next = CFD_MAP_SECOND;
      end else begin
        map_next = CFD_MAP_FIRST;
      end
    end
  end

  // Index is two's complement; its sign bit fills the upper address bits
  assign idx_ext = {{(ADDR_W-8){index_byte[7]}}, index_byte};
  // Carry out of the top bit is dropped: addresses wrap
  assign eff_next = ADDR_W'(base_addr + idx_ext);

  assign rd_mux = (reg_addr == ADDR_STATUS) ? status_now :
                  (reg_addr == ADDR_DECODE) ? {op_upper, op_lower} :
                  (reg_addr == ADDR_SAVED) ? stack_rd :
                  (reg_addr == ADDR_COND) ? {7'h00, cc_hit} : 8'h00;

  // Next values are settled here; the flops below only capture them
  assign rdata_next = reg_rd ? rd_mux : 8'h00;
  assign push_next = status_now;
  assign status_next = {arith_next, user_next};
  assign map_second = (map_next == CFD_MAP_SECOND);

  cfd_stack_mem #(
    .WIDTH(8),
    .DEPTH(1 << STACK_AW),
    .AW(STACK_AW)
  ) cfd_stack_mem_inst (
    .core_clk(core_clk),
    .wr_en(entry_evt),
    .wr_addr(push_addr),
    .wr_data(status_now),
    .rd_addr(top_addr),
    .rd_data(stack_rd)
  );

  // User bits sit outside the reset on purpose; reset also freezes them
  always_ff @(posedge core_clk) begin
    if (!rst) begin
      user_reg <= user_next;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      arith_reg <= ARITH_FLAGS_RESET;
    end else begin
      arith_reg <= arith_next;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sp_reg <= '0;
    end else begin
      sp_reg <= sp_next;
    end
  end

  // Restore lands one edge after the return, once the stack read is out
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      restore_pend_reg <= 1'b0;
    end else begin
      restore_pend_reg <= do_pop;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      map_reg <= CFD_MAP_FIRST;
    end else begin
      map_reg <= map_next;
    end
  end

  // Outputs are bare flops, so no path runs from an input to a pin
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_next;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_out <= 8'h00;
      branch_taken <= 1'b0;
    end else begin
      status_out <= status_next;
      branch_taken <= cc_hit;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      push_data <= 8'h00;
      push_valid <= 1'b0;
    end else begin
      push_data <= push_next;
      push_valid <= entry_evt;
    end
  end

  // op_upper and op_lower keep the last first-map opcode between strobes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      map_sel <= 1'b0;
      op_upper <= 4'h0;
      op_lower <= 4'h0;
      op_strobe <= 1'b0;
    end else begin
      map_sel <= map_second;
      op_strobe <= first_op;
      if (first_op) begin
        op_upper <= op_byte[7:4];
        op_lower <= op_byte[3:0];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      eff_addr <= '0;
    end else begin
      eff_addr <= eff_next;
    end
  end
endmodule : cfd_flags_decode

//--- cfd_sva.sv
/* Assertions on the status and decode block ports.
   Assumes one clock domain and the async high reset. */
`timescale 1ns/1ns
module cfd_sva import cfd_pkg::*; #(
  parameter int ADDR_W = 16
) (
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic alu_update, // alu
  input wire logic [5:0] alu_flags, // flags
  input wire logic [5:0] alu_mask, // mask
  input wire logic user_wr, // user
  input wire logic entry_evt, // entry
  input wire logic interrupt_return_instr, // return
  input wire logic op_valid, // op
  input wire logic [7:0] op_byte, // byte
  input wire logic [3:0] cc_code, // cond
  input wire logic [ADDR_W-1:0] base_addr, // base
  input wire logic [7:0] index_byte, // index
  input wire logic reg_wr, // write
  input wire logic [7:0] status_out, // status
  input wire logic branch_taken, // branch
  input wire logic [7:0] push_data, // push
  input wire logic push_valid, // push
  input wire logic map_sel, // map
  input wire logic [3:0] op_upper, // row
  input wire logic [3:0] op_lower, // col
  input wire logic op_strobe, // decoded
  input wire logic [ADDR_W-1:0] eff_addr // addr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Restore and register writes outrank ALU results
  sequence s_alu;
    alu_update && !reg_wr && !$past(interrupt_return_instr) && !$past(rst);
  endsequence
  sequence s_prefix;
    op_valid && !map_sel && op_byte == PREFIX_OPCODE;
  endsequence
  a_alu_load: assert property (s_alu ##0 alu_mask == 6'h3F |=>
    status_out[7:2] == $past(alu_flags)) else $error("alu flags not loaded");
  a_user_hold: assert property (s_alu ##0 !user_wr |=>
    status_out[1:0] == $past(status_out[1:0])) else $error("user bits moved");
  a_map_enter: assert property (s_prefix |=> map_sel && !op_strobe)
    else $error("prefix map wrong");
  a_map_leave: assert property (op_valid && map_sel |=> !map_sel)
    else $error("map not left");
  a_nib_decode: assert property (op_valid && !map_sel && op_byte != PREFIX_OPCODE |=>
    op_strobe && {op_upper, op_lower} == $past(op_byte)) else $error("decode wrong");
  a_push_entry: assert property (entry_evt && !$past(rst) |=>
    push_valid && push_data == $past(status_out)) else $error("push wrong");
  a_push_only: assert property (!entry_evt |=> !push_valid)
    else $error("stray push");
  a_idx_sext: assert property (!rst |=>
    eff_addr == $past(base_addr) + ADDR_W'($signed($past(index_byte))))
    else $error("index add wrong");
  a_cc_steady: assert property (!$past(rst) && $stable(status_out[7:4])
    && $stable(cc_code) |=> $stable(branch_taken)) else $error("branch moved");
endmodule : cfd_sva
bind cfd_flags_decode cfd_sva #(.ADDR_W(ADDR_W)) cfd_sva_inst (.core_clk, .rst,
  .alu_update, .alu_flags, .alu_mask, .user_wr, .entry_evt, .interrupt_return_instr,
  .op_valid, .op_byte, .cc_code, .base_addr, .index_byte, .reg_wr, .status_out,
  .branch_taken, .push_data, .push_valid, .map_sel, .op_upper, .op_lower, .op_strobe,
  .eff_addr);

//--- cfd_flags_decode_tb.sv
/* Testbench for the status and decode block.
   Drives every port itself; a monitor compares queued results. */
`timescale 1ns/1ns
module cfd_flags_decode_tb import cfd_pkg::*; ;
  logic core_clk, rst, alu_update, user_wr, entry_evt, interrupt_return_instr;
  logic op_valid, reg_wr, reg_rd, rd_d, bchk, branch_taken, push_valid, map_sel, op_strobe;
  logic [5:0] alu_flags, alu_mask;
  logic [1:0] user_val;
  logic [7:0] op_byte, index_byte, reg_wdata, reg_rdata, status_out, push_data, st, a, b;
  logic [3:0] cc_code, reg_addr, op_upper, op_lower;
  logic [15:0] base_addr, eff_addr;
  logic [7:0] qr[$];
  logic [7:0] qp[$];
  logic [7:0] qb[$];
  int fail_count;
  int num_checks;
  cfd_flags_decode cfd_flags_decode_inst (.core_clk, .rst, .alu_update, .alu_flags,
    .alu_mask, .user_wr, .user_val, .entry_evt, .interrupt_return_instr, .op_valid,
    .op_byte, .cc_code, .base_addr, .index_byte, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .status_out, .branch_taken, .push_data, .push_valid, .map_sel,
    .op_upper, .op_lower, .op_strobe, .eff_addr);
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic cmp_rd(input logic [7:0] g, input logic [7:0] e);
    cmp(g, e);
  endtask : cmp_rd
  task automatic cmp_push(input logic [7:0] g, input logic [7:0] e);
    cmp(g, e);
  endtask : cmp_push
  task automatic cmp_br(input logic [7:0] g, input logic [7:0] e);
    cmp(g, e);
  endtask : cmp_br
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge core_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, ad, d};
    @(posedge core_clk) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] ad, input logic [7:0] e);
    @(posedge core_clk) {reg_rd, reg_addr} <= {1'b1, ad};
    qr.push_back(e);
    @(posedge core_clk) reg_rd <= 1'b0;
  endtask : rd
  // Entry, return and opcode strobes share one pulse shape
  task automatic pul(input logic [2:0] k, input logic [7:0] ob);
    @(posedge core_clk) {entry_evt, interrupt_return_instr, op_valid, op_byte} <= {k, ob};
    if (k[2]) qp.push_back(st);
    @(posedge core_clk) {entry_evt, interrupt_return_instr, op_valid} <= 3'b000;
  endtask : pul
  task automatic alu(input logic [5:0] m, input logic [5:0] f);
    @(posedge core_clk) {alu_update, alu_mask, alu_flags} <= {1'b1, m, f};
    st[7:2] = (st[7:2] & ~m) | (f & m);
    @(posedge core_clk) alu_update <= 1'b0;
  endtask : alu
  function automatic logic cc_ev(input logic [7:0] s, input logic [3:0] c);
    logic r;
    case (c[2:0])
      3'h0: r = 1'b0;
      3'h1: r = s[5] ^ s[4];
      3'h2: r = s[6] | (s[5] ^ s[4]);
      3'h3: r = s[7] | s[6];
      3'h4: r = s[4];
      3'h5: r = s[5];
      3'h6: r = s[6];
      default: r = s[7];
    endcase
    return r ^ c[3];
  endfunction : cc_ev
  task automatic br(input logic [3:0] c);
    @(posedge core_clk) cc_code <= c;
    qb.push_back({7'h00, cc_ev(st, c)});
    repeat (2) @(posedge core_clk);
    bchk <= 1'b1;
    @(posedge core_clk) bchk <= 1'b0;
  endtask : br
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    rd_d <= reg_rd;
    base_addr <= 16'($urandom);
    index_byte <= 8'($urandom);
  end
  always @(negedge core_clk) begin
    if (rd_d) cmp_rd(reg_rdata, qr.pop_front());
    if (push_valid) cmp_push(push_data, qp.pop_front());
    if (bchk) cmp_br({7'h00, branch_taken}, qb.pop_front());
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    final_report();
  end
  initial begin
    {alu_update, user_wr, entry_evt, interrupt_return_instr, op_valid, reg_wr} = '0;
    {reg_rd, bchk, alu_flags, alu_mask, user_val, op_byte, cc_code} = '0;
    {reg_addr, reg_wdata} = '0;
    rst = 1'b1;
    void'($urandom(32'h704BD97A));
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      st = 8'($urandom);
      wr(ADDR_STATUS, st);
      rd(ADDR_STATUS, st);
      alu(6'h3F, 6'($urandom));
      alu(6'($urandom), 6'($urandom));
      rd(ADDR_STATUS, st);
      for (int c = 0; c < 16; c++) br(4'(c));
      a = 8'($urandom);
      @(posedge core_clk) {user_wr, user_val} <= {1'b1, a[1:0]};
      st[1:0] = a[1:0];
      @(posedge core_clk) user_wr <= 1'b0;
      b = st;
      pul(3'b100, 8'h00);
      wr(ADDR_STATUS, ~b);
      st = ~b;
      pul(3'b100, 8'h00);
      pul(3'b010, 8'h00);
      rd(ADDR_STATUS, st);
      pul(3'b010, 8'h00);
      st = b;
      rd(ADDR_STATUS, st);
      a = a | 8'h80;
      pul(3'b001, a);
      rd(ADDR_DECODE, a);
      pul(3'b001, PREFIX_OPCODE);
      pul(3'b001, ~a);
      rd(ADDR_DECODE, a);
    end
    // Unmapped offsets ignore writes (offset 9) and read zero (offset F)
    wr(4'h9, 8'h5A);
    rd(4'hF, 8'h00);
    rd(ADDR_STATUS, st);
    @(posedge core_clk) rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    st[7:2] = ARITH_FLAGS_RESET;
    rd(ADDR_STATUS, st);
    repeat (3) @(posedge core_clk);
    if (qr.size() + qp.size() + qb.size() != 0) fail_count++;
    final_report();
  end
endmodule : cfd_flags_decode_tb
